// >>> include/thermal_button_irq_consts.svh
// register map, field positions, reset values and timing for the irq bank
`ifndef THERMAL_BUTTON_IRQ_CONSTS_SVH
`define THERMAL_BUTTON_IRQ_CONSTS_SVH

// ***********************************************************
// register offsets
// ***********************************************************
`define ADDR_THERMAL_STATUS 8'h20
`define ADDR_THERMAL_MASK   8'h21
`define ADDR_THERMAL_SENSE  8'h22
`define ADDR_BUTTON_STATUS  8'h24
`define ADDR_BUTTON_MASK    8'h25
`define ADDR_BUTTON_SENSE   8'h26

// ***********************************************************
// field positions and valid bits
// ***********************************************************
`define THERMAL_LOW_BIT     0
`define THERMAL_HIGH_BIT    2
`define BUTTON_CHANGE_BIT   0
`define BUTTON_HELD_LSB     1
`define THERMAL_VALID       8'h05
`define BUTTON_VALID        8'h3f

// ***********************************************************
// reset values
// ***********************************************************
`define STATUS_RESET        8'h00
`define THERMAL_MASK_RESET  8'h05
`define BUTTON_MASK_RESET   8'h3f

// ***********************************************************
// timing
// ***********************************************************
`define CLK_HZ              20000000
`define HOLD_UNIT_S         1
`define HELD_1S             1
`define HELD_2S             2
`define HELD_3S             3
`define HELD_4S             4
`define HELD_8S             8

`endif

// >>> include/thermal_button_irq_pkg.sv
// types shared by the thermal and button interrupt bank
package thermal_button_irq_pkg;

	// debounce states, gray coded around the press/release loop
	typedef enum logic [1:0] {
		DB_RELEASED = 2'b00,
		DB_FALL_CHK = 2'b01,
		DB_PRESSED  = 2'b11,
		DB_RISE_CHK = 2'b10
	} debounce_state_type;

endpackage

// >>> design/thermal_button_irq_bank.sv
// thermal and power button interrupt status, mask and sense bank
// Operation
// [R01] lower thermal flag, bit 0, sets on any crossing of 110 C
// [R02] upper thermal flag, bit 2, sets on any crossing of 125 C; bit 1 unused
// [R03] status bits reset to 0, clear on read or on writing a 1
// [R04] thermal mask bits 0 and 2 are read-write and reset to 1
// [R05] interrupt pin low while any unmasked status bit is set
// [R06] thermal sense bit 0 shows live 110 C comparator, reset 0
// [R07] thermal sense bit 2 shows live 125 C comparator; writes ignored
// [R08] change flag sets when button stays low past falling debounce time
// [R09] change flag sets on release past rising debounce after a valid press
// [R10] change flag sets on every change of debounced pressed state
// [R11] held 1 s flag, bit 1, sets after more than 1 s held
// [R12] held flags bits 2..5 set after 2, 3, 4, 8 s; bits 7..6 unused
// [R13] button mask bit 0 masks the change flag, resets to 1
// [R14] button mask bits 1 and 2 mask held 1 s and 2 s flags
// [R15] readable debounced pressed sense bit
// [R16] held sense bits stay while held, clear on debounced release
// [R17] unused bits read 0 and ignore writes
// [R18] an event in the same cycle as its clear leaves the bit set
`timescale 1ns/1ps
`include "thermal_button_irq_consts.svh"

module thermal_button_irq_bank
	import thermal_button_irq_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `HOLD_UNIT_S * `CLK_HZ
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        temp_above_110,
	input  wire logic        temp_above_125,
	input  wire logic        power_button_n,
	input  wire logic [15:0] fall_debounce,
	input  wire logic [15:0] rise_debounce,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             irq_out_n
);

	// ***********************************************************
	// state
	// ***********************************************************
	logic               thermal_low_live;
	logic               thermal_high_live;
	logic [7:0]         thermal_irq_status;
	logic [7:0]         thermal_irq_mask;
	logic [7:0]         button_irq_status;
	logic [7:0]         button_irq_mask;
	logic               button_pressed_live;
	logic [4:0]         held_live;
	debounce_state_type db_state;
	logic [15:0]        db_cnt;
	logic [27:0]        held_cnt;

	logic [7:0]         next_thermal_status;
	logic [7:0]         next_button_status;
	logic [7:0]         thermal_set;
	logic [7:0]         thermal_clr;
	logic [7:0]         button_set;
	logic [7:0]         button_clr;
	logic [4:0]         held_hit;
	logic               button_change_ev;
	logic               thermal_low_ev;
	logic               thermal_high_ev;
	logic [7:0]         rd_value;

	localparam int unsigned HELD_SECS [5] = '{`HELD_1S, `HELD_2S, `HELD_3S,
		`HELD_4S, `HELD_8S};
	localparam logic [27:0] HELD_LIMIT = 28'(`HELD_8S * SEC_CYCLES + 1);

	// ***********************************************************
	// register port decode
	// ***********************************************************
	logic wr_thermal_status;
	logic wr_thermal_mask;
	logic wr_button_status;
	logic wr_button_mask;
	logic rd_thermal_status;
	logic rd_button_status;

	assign wr_thermal_status = reg_wr && (reg_addr == `ADDR_THERMAL_STATUS);
	assign wr_thermal_mask   = reg_wr && (reg_addr == `ADDR_THERMAL_MASK);
	assign wr_button_status  = reg_wr && (reg_addr == `ADDR_BUTTON_STATUS);
	assign wr_button_mask    = reg_wr && (reg_addr == `ADDR_BUTTON_MASK);
	assign rd_thermal_status = reg_rd && (reg_addr == `ADDR_THERMAL_STATUS);
	assign rd_button_status  = reg_rd && (reg_addr == `ADDR_BUTTON_STATUS);

	// ***********************************************************
	// thermal comparators
	// ***********************************************************
	// a crossing either way is a mismatch between comparator and its copy
	assign thermal_low_ev  = temp_above_110 ^ thermal_low_live;  // R01
	assign thermal_high_ev = temp_above_125 ^ thermal_high_live; // R02

	// live copies feed the sense register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thermal_low_live  <= 1'b0;
			thermal_high_live <= 1'b0;
		end else begin
			thermal_low_live  <= temp_above_110; // R06
			thermal_high_live <= temp_above_125; // R07
		end
	end

	// ***********************************************************
	// button debounce
	// ***********************************************************
	// one counter serves both edges; a bounce restarts the check
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			db_state            <= DB_RELEASED;
			db_cnt              <= 16'h0000;
			button_pressed_live <= 1'b0;
		end else begin
			unique case (db_state)
				DB_RELEASED: begin
					db_cnt <= 16'h0000;
					if (!power_button_n) begin
						db_state <= DB_FALL_CHK;
					end
				end
				DB_FALL_CHK: begin
					db_cnt <= db_cnt + 16'h0001;
					if (power_button_n) begin
						db_state <= DB_RELEASED;
					end else if (db_cnt >= fall_debounce) begin
						db_state            <= DB_PRESSED; // R08
						button_pressed_live <= 1'b1;       // R15
					end
				end
				DB_PRESSED: begin
					db_cnt <= 16'h0000;
					if (power_button_n) begin
						db_state <= DB_RISE_CHK;
					end
				end
				DB_RISE_CHK: begin
					db_cnt <= db_cnt + 16'h0001;
					if (!power_button_n) begin
						db_state <= DB_PRESSED;
					end else if (db_cnt >= rise_debounce) begin
						db_state            <= DB_RELEASED; // R09
						button_pressed_live <= 1'b0;        // R15
					end
				end
			endcase
		end
	end

	// the change event is the debounced state about to flip
	assign button_change_ev =
		((db_state == DB_FALL_CHK) && !power_button_n && (db_cnt >= fall_debounce)) ||
		((db_state == DB_RISE_CHK) && power_button_n && (db_cnt >= rise_debounce)); // R10

	// ***********************************************************
	// held duration
	// ***********************************************************
	// counter saturates just past the longest threshold to bound its width
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held_cnt <= 28'h0000000;
		end else if (!button_pressed_live) begin
			held_cnt <= 28'h0000000;
		end else if (held_cnt != HELD_LIMIT) begin
			held_cnt <= held_cnt + 28'h0000001;
		end
	end

	// strictly more than n seconds held
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			held_hit[k] = button_pressed_live &&
				(held_cnt > 28'(HELD_SECS[k] * SEC_CYCLES)); // R11 R12
		end
	end

	// sense bits drop one clock after the debounced pressed bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held_live <= 5'h00;
		end else begin
			held_live <= held_hit; // R16
		end
	end

	// ***********************************************************
	// status registers
	// ***********************************************************
	// set is or-ed after the clear so a colliding event survives
	always_comb begin
		thermal_set = 8'h00;
		thermal_set[`THERMAL_LOW_BIT]  = thermal_low_ev;  // R01
		thermal_set[`THERMAL_HIGH_BIT] = thermal_high_ev; // R02
		thermal_clr = (wr_thermal_status ? reg_wdata : 8'h00) |
			(rd_thermal_status ? 8'hff : 8'h00); // R03
		next_thermal_status = ((thermal_irq_status & ~thermal_clr) | thermal_set) &
			`THERMAL_VALID; // R18 R17
		button_set = 8'h00;
		button_set[`BUTTON_CHANGE_BIT] = button_change_ev; // R10
		button_set[`BUTTON_HELD_LSB +: 5] = held_hit & ~held_live; // R11 R12
		button_clr = (wr_button_status ? reg_wdata : 8'h00) |
			(rd_button_status ? 8'hff : 8'h00); // R03
		next_button_status = ((button_irq_status & ~button_clr) | button_set) &
			`BUTTON_VALID; // R18 R17
	end

	// latched flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thermal_irq_status <= `STATUS_RESET; // R03
			button_irq_status  <= `STATUS_RESET;
		end else begin
			thermal_irq_status <= next_thermal_status;
			button_irq_status  <= next_button_status;
		end
	end

	// ***********************************************************
	// mask registers
	// ***********************************************************
	// reset masked so nothing reaches the pin before software is ready
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thermal_irq_mask <= `THERMAL_MASK_RESET; // R04
			button_irq_mask  <= `BUTTON_MASK_RESET;  // R13 R14
		end else begin
			if (wr_thermal_mask) begin
				thermal_irq_mask <= reg_wdata & `THERMAL_VALID; // R04 R17
			end
			if (wr_button_mask) begin
				button_irq_mask <= reg_wdata & `BUTTON_VALID; // R13 R14
			end
		end
	end

	// ***********************************************************
	// read port and interrupt pin
	// ***********************************************************
	// sense registers have no write path at all
	always_comb begin
		unique case (reg_addr)
			`ADDR_THERMAL_STATUS: rd_value = thermal_irq_status;
			`ADDR_THERMAL_MASK:   rd_value = thermal_irq_mask;
			`ADDR_THERMAL_SENSE:  rd_value = {5'h00, thermal_high_live, 1'b0,
				thermal_low_live}; // R06 R07
			`ADDR_BUTTON_STATUS:  rd_value = button_irq_status;
			`ADDR_BUTTON_MASK:    rd_value = button_irq_mask;
			`ADDR_BUTTON_SENSE:   rd_value = {2'h0, held_live,
				button_pressed_live}; // R15 R16
			default:              rd_value = 8'h00; // R17
		endcase
	end

	// read data is the value before the read clears it; held until next read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_value;
		end
	end

	// pin lags the status registers by one clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= ~|((thermal_irq_status & ~thermal_irq_mask) |
				(button_irq_status & ~button_irq_mask)); // R05
		end
	end

	// ***********************************************************
	// assertions
	// ***********************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_low_crossing;
		(temp_above_110 != thermal_low_live) |=> thermal_irq_status[0];
	endproperty
	a_low_crossing: assert property (p_low_crossing) // R01
		else $error("low thermal crossing not latched");

	property p_high_crossing;
		(temp_above_125 != thermal_high_live) |=> thermal_irq_status[2];
	endproperty
	a_high_crossing: assert property (p_high_crossing) // R02
		else $error("high thermal crossing not latched");

	property p_read_clears;
		(rd_thermal_status && !reg_wr && !thermal_low_ev && !thermal_high_ev)
			|=> (thermal_irq_status == 8'h00);
	endproperty
	a_read_clears: assert property (p_read_clears) // R03
		else $error("thermal status not cleared by read");

	property p_pin_low;
		((thermal_irq_status & ~thermal_irq_mask) != 8'h00) |=> !irq_out_n;
	endproperty
	a_pin_low: assert property (p_pin_low) // R05
		else $error("unmasked status did not pull pin low");

	property p_pin_high;
		(((thermal_irq_status & ~thermal_irq_mask) |
			(button_irq_status & ~button_irq_mask)) == 8'h00) |=> irq_out_n;
	endproperty
	a_pin_high: assert property (p_pin_high) // R05
		else $error("pin low with nothing unmasked");

	property p_live_flags;
		$changed(thermal_low_live) |-> thermal_irq_status[0];
	endproperty
	a_live_flags: assert property (p_live_flags) // R06
		else $error("sense change without status flag");

	property p_press_debounced;
		$rose(button_pressed_live) |-> $past(db_state) == DB_FALL_CHK &&
			!$past(power_button_n) && button_irq_status[0];
	endproperty
	a_press_debounced: assert property (p_press_debounced) // R08
		else $error("press not debounced or not flagged");

	property p_release_flag;
		$fell(button_pressed_live) |-> button_irq_status[0];
	endproperty
	a_release_flag: assert property (p_release_flag) // R10
		else $error("release did not flag change");

	property p_held_clear;
		$fell(button_pressed_live) |=> (held_live == 5'h00);
	endproperty
	a_held_clear: assert property (p_held_clear) // R16
		else $error("held sense survived release");

	property p_set_wins;
		(wr_button_status && reg_wdata[0] && button_change_ev) |=> button_irq_status[0];
	endproperty
	a_set_wins: assert property (p_set_wins) // R18
		else $error("event lost against clear");

	property p_unused_zero;
		(thermal_irq_status[1] == 1'b0) && (button_irq_status[7:6] == 2'h0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) // R17
		else $error("unused status bit set");

endmodule // thermal_button_irq_bank

// >>> verif/host_model.sv
// host processor model: drives the register port and watches the interrupt line
`timescale 1ns/1ps

module host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       irq_out_n,
	output logic      [7:0] reg_addr,
	output logic            reg_rd,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata
);
	// ***********************************************************
	// register access
	// ***********************************************************
	// idle cycles before each access, raised to play a slow host
	int idle_gap = 0;

	// quiet port at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end

	// one read strobe; reading a status register is also how it gets cleared
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		repeat (idle_gap) @(posedge clk);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a; // released lines carry junk so a stale address never looks valid
		@(negedge clk);
		d = reg_rdata;
	endtask

	// one write strobe; ones written to a status register clear those bits
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		repeat (idle_gap) @(posedge clk);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~v;
	endtask

	// level of the interrupt line once the clock edge has settled
	task automatic irq_seen(output logic l);
		@(negedge clk);
		l = irq_out_n;
	endtask
endmodule // host_model

// >>> verif/thermal_button_irq_bank_tb.sv
// self-checking bench for the thermal and button interrupt bank
`timescale 1ns/1ps
`include "thermal_button_irq_consts.svh"

module thermal_button_irq_bank_tb;
	// short second keeps the held-button runs within a few hundred cycles
	localparam int unsigned SEC  = 40;
	localparam logic [15:0] FALL = 16'h0005;
	localparam logic [15:0] RISE = 16'h0004;

	logic        clk;
	logic        rst_n;
	logic        temp_above_110;
	logic        temp_above_125;
	logic        power_button_n;
	logic [7:0]  reg_addr;
	logic        reg_rd;
	logic        reg_wr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        irq_out_n;
	logic [31:0] seed;
	logic [7:0]  addr;
	int          err_total;
	int          cmp_count;
	int          hold;
	int          held_n [5] = '{1, 2, 3, 4, 8};

	thermal_button_irq_bank #(.SEC_CYCLES(SEC)) i_thermal_button_irq_bank (
		.clk(clk), .rst_n(rst_n), .temp_above_110(temp_above_110),
		.temp_above_125(temp_above_125), .power_button_n(power_button_n),
		.fall_debounce(FALL), .rise_debounce(RISE), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .irq_out_n(irq_out_n));

	host_model i_host_model (
		.clk(clk), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));

	// ***********************************************************
	// helpers
	// ***********************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host_model.rd(a, d);
		chk(d, exp);
	endtask

	// status reaches the pin two edges after its cause
	task automatic irq_chk(input logic exp);
		logic l;
		repeat (3) @(posedge clk);
		i_host_model.irq_seen(l);
		chk({7'h00, l}, {7'h00, exp});
	endtask

	task automatic drive_temp(input logic lo, input logic hi);
		@(posedge clk);
		temp_above_110 <= lo;
		temp_above_125 <= hi;
		repeat (3) @(posedge clk);
	endtask

	task automatic drive_btn(input logic v, input int n);
		@(posedge clk);
		power_button_n <= v;
		repeat (n) @(posedge clk);
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// only the valid bits of a mask register keep what is written
	function automatic logic [7:0] mask_exp(input logic [7:0] a, input logic [7:0] v);
		return (a == `ADDR_THERMAL_MASK) ? (v & `THERMAL_VALID) : (v & `BUTTON_VALID);
	endfunction

	// change flag plus every held flag whose threshold the hold has passed
	function automatic logic [7:0] held_exp(input int hc);
		logic [7:0] e;
		e = 8'h01;
		for (int k = 0; k < 5; k++) begin
			if (hc > held_n[k] * SEC + 2) e[k + 1] = 1'b1;
		end
		return e;
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// clock at 20 MHz
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		rst_n = 1'b0;
		temp_above_110 = 1'b0;
		temp_above_125 = 1'b0;
		power_button_n = 1'b1;
		err_total = 0;
		cmp_count = 0;
		seed = 32'h120c;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rchk(`ADDR_THERMAL_MASK, 8'h05);
		rchk(`ADDR_BUTTON_MASK, 8'h3f);
		rchk(`ADDR_THERMAL_STATUS, 8'h00);
		rchk(`ADDR_BUTTON_STATUS, 8'h00);
		rchk(`ADDR_THERMAL_SENSE, 8'h00);
		rchk(`ADDR_BUTTON_SENSE, 8'h00);
		irq_chk(1'b1);
		// masked thermal crossings latch but leave the pin alone
		drive_temp(1'b1, 1'b0);
		irq_chk(1'b1);
		rchk(`ADDR_THERMAL_SENSE, 8'h01);
		rchk(`ADDR_THERMAL_STATUS, 8'h01);
		rchk(`ADDR_THERMAL_STATUS, 8'h00);
		drive_temp(1'b1, 1'b1);
		i_host_model.wr(`ADDR_THERMAL_SENSE, 8'hff);
		rchk(`ADDR_THERMAL_SENSE, 8'h05);
		rchk(`ADDR_THERMAL_STATUS, 8'h04);
		i_host_model.wr(`ADDR_THERMAL_MASK, 8'h00);
		rchk(`ADDR_THERMAL_MASK, 8'h00);
		// falling crossings of both levels, cleared one bit at a time
		drive_temp(1'b0, 1'b0);
		irq_chk(1'b0);
		i_host_model.wr(`ADDR_THERMAL_STATUS, 8'h01);
		irq_chk(1'b0);
		rchk(`ADDR_THERMAL_STATUS, 8'h04);
		irq_chk(1'b1);
		// random mask writes and an unmapped place, with a slow host
		i_host_model.idle_gap = 2;
		for (int i = 0; i < 6; i++) begin
			seed = lfsr_next(seed);
			addr = seed[0] ? `ADDR_THERMAL_MASK : `ADDR_BUTTON_MASK;
			i_host_model.wr(addr, seed[15:8]);
			rchk(addr, mask_exp(addr, seed[15:8]));
		end
		i_host_model.wr(8'h23, seed[23:16]);
		rchk(8'h23, 8'h00);
		i_host_model.idle_gap = 0;
		i_host_model.wr(`ADDR_BUTTON_MASK, 8'h3e);
		rchk(`ADDR_BUTTON_MASK, 8'h3e);
		// a press shorter than the falling debounce raises nothing
		seed = lfsr_next(seed);
		drive_btn(1'b0, int'(seed[7:0]) % FALL + 1);
		drive_btn(1'b1, 6);
		rchk(`ADDR_BUTTON_STATUS, 8'h00);
		// a write-one clear landing on the press edge must not lose the event
		drive_btn(1'b0, 5);
		i_host_model.wr(`ADDR_BUTTON_STATUS, 8'h01);
		rchk(`ADDR_BUTTON_STATUS, 8'h01);
		drive_btn(1'b1, RISE + 6);
		rchk(`ADDR_BUTTON_STATUS, 8'h01);
		// one press for each held threshold, then release
		for (int k = 0; k < 5; k++) begin
			hold = held_n[k] * SEC + SEC / 2;
			drive_btn(1'b0, FALL + 3 + hold);
			irq_chk(1'b0);
			rchk(`ADDR_BUTTON_STATUS, held_exp(hold));
			rchk(`ADDR_BUTTON_SENSE, held_exp(hold));
			irq_chk(1'b1);
			drive_btn(1'b1, RISE + 6);
			rchk(`ADDR_BUTTON_SENSE, 8'h00);
			rchk(`ADDR_BUTTON_STATUS, 8'h01);
		end
		tally_and_finish();
	end
endmodule // thermal_button_irq_bank_tb
